// [sdpp_host_model.sv]
// host controller model driving the parallel and serial programming pins
`timescale 1ns/1ps
module sdpp_host_model (
  // clock
  input logic mclk,
  // parallel pins
  output logic parallelLoadN,
  output logic [8:0] feedbackDivideBits,
  output logic [2:0] outputDivideBits,
  // serial pins
  output logic serialClock,
  output logic serialData,
  output logic serialLoad
);
  initial begin
    parallelLoadN = 1'b0;
    feedbackDivideBits = 9'h020;
    outputDivideBits = 3'h3;
    serialClock = 1'b0;
    serialData = 1'b0;
    serialLoad = 1'b0;
  end
  task automatic par(input logic pl, input logic [8:0] m, input logic [2:0] n);
    @(posedge mclk);
    feedbackDivideBits <= m;
    outputDivideBits <= n;
    repeat (4) @(posedge mclk);
    parallelLoadN <= pl;
    if (pl) begin
      repeat (4) @(posedge mclk);
      // latched pins no longer matter
      feedbackDivideBits <= ~m;
      outputDivideBits <= ~n;
    end
  endtask : par
  task automatic shift(input logic [17:0] v, input int n);
    // keep link edges off the rising clock edge
    #1;
    for (int i = n - 1; i >= 0; i--) begin
      serialData = v[i];
      #62.5 serialClock = 1'b1;
      #62.5 serialClock = 1'b0;
    end
    serialData = 1'b0;
  endtask : shift
  task automatic load(input logic lv);
    #50 serialLoad = lv;
    #50;
  endtask : load
endmodule : sdpp_host_model

// [sdpp_pin_sync.sv]
// two-stage synchroniser with edge detection for the programming pins
`timescale 1ns/1ps
module sdpp_pin_sync import sdpp_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // raw pins
  input wire logic [SYNC_W-1:0] rawPins,
  // synchronised view
  sdpp_pins_if.src pins
);
  logic [SYNC_W-1:0] stage1;
  logic [SYNC_W-1:0] stage2;
  logic [SYNC_W-1:0] stage3;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= rawPins;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // edges seen only past the second stage
  assign pins.level = stage2;
  assign pins.rise = stage2 & ~stage3;
  assign pins.fall = ~stage2 & stage3;
endmodule : sdpp_pin_sync

// [sdpp_pins_if.sv]
// synchronised pin levels and edges passed from the synchroniser to the core
`timescale 1ns/1ps
interface sdpp_pins_if import sdpp_pkg::*; ();
  logic [SYNC_W-1:0] level;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sdpp_pins_if

// [sdpp_pkg.sv]
// shared constants and types of the synthesizer programming port
package sdpp_pkg;
  // timing of the spread modulation triangle
  localparam int CLK_HZ = 100_000_000;
  localparam int MOD_RATE_HZ = 32_000;
  localparam int MOD_PERIOD_CYC = CLK_HZ / MOD_RATE_HZ;
  localparam int TRI_STEPS = 32;
  localparam int STEP_CYC = MOD_PERIOD_CYC / TRI_STEPS;
  localparam logic [6:0] STEP_LAST = 7'(STEP_CYC - 1);
  localparam logic [4:0] TRI_PEAK = 5'(TRI_STEPS / 2);
  // synchronised pin indices
  localparam int SYNC_W = 6;
  localparam int PIN_PLOADN = 0;
  localparam int PIN_SLOAD = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDATA = 3;
  localparam int PIN_FBTAP = 4;
  localparam int PIN_BATAP = 5;
  // serial frame: spread, diag select, output divide, feedback divide
  localparam int SHIFT_W = 18;
  localparam int FB_LSB = 0;
  localparam int OD_LSB = 9;
  localparam int DIAG_LSB = 12;
  localparam int SPREAD_LSB = 14;
  localparam int PAR_W = 12;
  // reset values
  localparam logic [8:0] FB_RESET = 9'h020;
  localparam logic [2:0] OD_RESET = 3'h3;
  localparam logic [3:0] SPREAD_RESET = 4'h0;
  localparam logic [1:0] DIAG_RESET = 2'h0;
  localparam logic [6:0] CTRL_RESET = 7'h46;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SHIFT = 8'h08;
  localparam logic [7:0] REG_SPREAD = 8'h0C;
  // control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_MR = 0;
  localparam int CTRL_OEA = 1;
  localparam int CTRL_OEB = 2;
  localparam int CTRL_OEREF = 3;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_VCO = 6;
  // output divider codes
  localparam logic [2:0] OD_DIV2 = 3'h1;
  localparam logic [2:0] OD_DIV4 = 3'h3;
  localparam logic [2:0] OD_DIV5 = 3'h4;
  // spread depth in hundredths of a percent, by level
  localparam logic [7:0] CENTER_DEPTH [5] = '{8'h00, 8'h19, 8'h55, 8'h91, 8'hAA};
  localparam logic [7:0] DOWN_DEPTH [5] = '{8'h00, 8'h19, 8'h4B, 8'h7D, 8'h96};
  typedef enum logic [1:0] {DIAG_LOW = 2'h0, DIAG_SHIFT = 2'h1, DIAG_FBDIV = 2'h2,
                            DIAG_BANKA = 2'h3} sdpp_diag_t;
  typedef enum logic [1:0] {SPREAD_OFF = 2'h0, SPREAD_CENTER = 2'h1,
                            SPREAD_DOWN = 2'h2} sdpp_spread_t;
  typedef enum logic [1:0] {SRC_DIFF = 2'h0, SRC_SINGLE = 2'h1, SRC_XTAL0 = 2'h2,
                            SRC_XTAL1 = 2'h3} sdpp_src_t;
  typedef enum logic [2:0] {LD_PARALLEL = 3'h1, LD_SHIFT = 3'h2, LD_PASS = 3'h4} sdpp_load_t;
endpackage : sdpp_pkg

// [sdpp_program_port.sv]
// programming and control core of the frequency synthesizer
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sdpp_program_port import sdpp_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // parallel programming pins
  input wire logic parallelLoadN,
  input wire logic [8:0] feedbackDivideBits,
  input wire logic [2:0] outputDivideBits,
  // serial programming pins
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serialLoad,
  // analog taps for the diag output
  input wire logic feedbackDividerTap,
  input wire logic bankATap,
  // divider settings
  output logic [8:0] feedbackDivide,
  output logic [2:0] outputDivide,
  output logic [2:0] outputDivideRatio,
  output logic pllRelock,
  // diag output
  output logic diagOutput,
  // spread modulation
  output logic [1:0] spreadMode,
  output logic [7:0] spreadDepth,
  output logic [4:0] spreadPhase,
  // pll and output control
  output logic pllReset,
  output logic vcoMinimum,
  output logic dividersEnable,
  output logic bankAEnable,
  output logic bankBEnable,
  output logic refCopyEnable,
  output logic [1:0] refSource,
  output logic pllBypass
);
  sdpp_pins_if pins ();

  logic [PAR_W-1:0] parStage1;
  logic [PAR_W-1:0] parStage2;
  logic [SHIFT_W-1:0] shiftReg;
  logic [1:0] diagSelect;
  logic [3:0] spreadSelect;
  logic [CTRL_W-1:0] ctrl;
  sdpp_load_t loadState;
  logic [8:0] next_feedbackDivide;
  logic [2:0] next_outputDivide;
  logic [1:0] next_diagSelect;
  logic [3:0] next_spreadSelect;
  logic [SHIFT_W-1:0] next_shiftReg;
  sdpp_load_t next_loadState;
  logic [SHIFT_W-1:0] frame;
  logic loadFrame;
  logic pLoadN;
  logic sLoad;
  logic sClkRise;
  logic sLoadRise;
  logic sLoadFall;
  logic [31:0] readData;
  logic readError;
  logic apbDone;
  logic triRun;

  // pin decoding helpers
  function automatic logic [2:0] spread_level(input logic [2:0] code);
    logic [2:0] level;
    level = 3'h0;
    if (code == 3'h0) begin
      level = 3'h0;
    end else if (code <= 3'h2) begin
      level = 3'h1;
    end else if (code <= 3'h4) begin
      level = 3'h2;
    end else if (code <= 3'h6) begin
      level = 3'h3;
    end else begin
      level = 3'h4;
    end
    return level;
  endfunction : spread_level

  function automatic logic [1:0] spread_kind(input logic [3:0] sel);
    logic [1:0] kind;
    kind = SPREAD_OFF;
    if (sel[2:0] == 3'h0) begin
      kind = SPREAD_OFF;
    end else if (sel[3]) begin
      kind = SPREAD_DOWN;
    end else begin
      kind = SPREAD_CENTER;
    end
    return kind;
  endfunction : spread_kind

  function automatic logic [2:0] divide_ratio(input logic [2:0] code);
    logic [2:0] ratio;
    ratio = 3'h0;
    if (code == OD_DIV2) begin
      ratio = 3'h2;
    end else if (code == OD_DIV4) begin
      ratio = 3'h4;
    end else if (code == OD_DIV5) begin
      ratio = 3'h5;
    end
    return ratio;
  endfunction : divide_ratio

  sdpp_pin_sync u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .rawPins({bankATap, feedbackDividerTap, serialData, serialClock, serialLoad,
              parallelLoadN}),
    .pins(pins.src)
  );

  // parallel bus synchroniser
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // start at the default pins so release causes no false divider change
      parStage1 <= {OD_RESET, FB_RESET};
      parStage2 <= {OD_RESET, FB_RESET};
    end else begin
      parStage1 <= {outputDivideBits, feedbackDivideBits};
      parStage2 <= parStage1;
    end
  end

  assign pLoadN = pins.level[PIN_PLOADN];
  assign sLoad = pins.level[PIN_SLOAD];
  assign sClkRise = pins.rise[PIN_SCLK];
  assign sLoadRise = pins.rise[PIN_SLOAD];
  assign sLoadFall = pins.fall[PIN_SLOAD];

  // next divider, shift and mode values
  always_comb begin
    next_feedbackDivide = feedbackDivide;
    next_outputDivide = outputDivide;
    next_diagSelect = diagSelect;
    next_spreadSelect = spreadSelect;
    next_shiftReg = shiftReg;
    next_loadState = loadState;
    frame = shiftReg;
    loadFrame = 1'b0;
    if (!pLoadN) begin
      next_feedbackDivide = parStage2[OD_LSB-1:FB_LSB];
      next_outputDivide = parStage2[PAR_W-1:OD_LSB];
      next_spreadSelect = SPREAD_RESET;
      next_loadState = LD_PARALLEL;
    end else begin
      if (sClkRise) begin
        next_shiftReg = {shiftReg[SHIFT_W-2:0], pins.level[PIN_SDATA]};
      end
      loadFrame = sLoadRise || (sLoad && sClkRise);
      frame = next_shiftReg;
      case (loadState)
        LD_PARALLEL: begin
          if (sLoad) begin
            next_loadState = LD_PASS;
          end else if (sClkRise) begin
            next_loadState = LD_SHIFT;
          end
        end
        LD_SHIFT: begin
          if (sLoadRise) begin
            next_loadState = LD_PASS;
          end
        end
        LD_PASS: begin
          if (sLoadFall) begin
            next_loadState = LD_SHIFT;
          end
        end
        default: begin
          next_loadState = LD_SHIFT;
        end
      endcase
    end
    if (pLoadN && loadFrame) begin
      next_feedbackDivide = frame[OD_LSB-1:FB_LSB];
      next_outputDivide = frame[DIAG_LSB-1:OD_LSB];
      next_diagSelect = frame[SPREAD_LSB-1:DIAG_LSB];
      next_spreadSelect = frame[SHIFT_W-1:SPREAD_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      feedbackDivide <= FB_RESET;
      outputDivide <= OD_RESET;
      diagSelect <= DIAG_RESET;
      spreadSelect <= SPREAD_RESET;
      shiftReg <= '0;
      loadState <= LD_PARALLEL;
    end else begin
      feedbackDivide <= next_feedbackDivide;
      outputDivide <= next_outputDivide;
      diagSelect <= next_diagSelect;
      spreadSelect <= next_spreadSelect;
      shiftReg <= next_shiftReg;
      loadState <= next_loadState;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pllRelock <= 1'b0;
    end else begin
      pllRelock <= (next_feedbackDivide != feedbackDivide);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      outputDivideRatio <= 3'h0;
    end else begin
      outputDivideRatio <= divide_ratio(outputDivide);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      diagOutput <= 1'b0;
    end else if (loadState == LD_PARALLEL) begin
      diagOutput <= 1'b0;
    end else begin
      case (diagSelect)
        DIAG_LOW: diagOutput <= 1'b0;
        DIAG_SHIFT: diagOutput <= shiftReg[SHIFT_W-1];
        DIAG_FBDIV: diagOutput <= pins.level[PIN_FBTAP];
        default: diagOutput <= pins.level[PIN_BATAP];
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      spreadMode <= SPREAD_OFF;
      spreadDepth <= 8'h00;
    end else begin
      spreadMode <= spread_kind(spreadSelect);
      if (spreadSelect[3]) begin
        spreadDepth <= DOWN_DEPTH[spread_level(spreadSelect[2:0])];
      end else begin
        spreadDepth <= CENTER_DEPTH[spread_level(spreadSelect[2:0])];
      end
    end
  end

  assign triRun = (spreadMode != SPREAD_OFF) && !pllReset;

  sdpp_triangle u_tri (
    .mclk(mclk),
    .resetn(resetn),
    .run(triRun),
    .phase(spreadPhase)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pllReset <= CTRL_RESET[CTRL_MR];
      vcoMinimum <= CTRL_RESET[CTRL_MR];
      dividersEnable <= !CTRL_RESET[CTRL_MR];
      bankAEnable <= CTRL_RESET[CTRL_OEA] && !CTRL_RESET[CTRL_MR];
      bankBEnable <= CTRL_RESET[CTRL_OEB] && !CTRL_RESET[CTRL_MR];
      refCopyEnable <= CTRL_RESET[CTRL_OEREF] && !CTRL_RESET[CTRL_MR];
      refSource <= CTRL_RESET[CTRL_SEL_LSB+1:CTRL_SEL_LSB];
      pllBypass <= !CTRL_RESET[CTRL_VCO];
    end else begin
      pllReset <= ctrl[CTRL_MR];
      vcoMinimum <= ctrl[CTRL_MR];
      dividersEnable <= !ctrl[CTRL_MR];
      bankAEnable <= ctrl[CTRL_OEA] && !ctrl[CTRL_MR];
      bankBEnable <= ctrl[CTRL_OEB] && !ctrl[CTRL_MR];
      refCopyEnable <= ctrl[CTRL_OEREF] && !ctrl[CTRL_MR];
      refSource <= ctrl[CTRL_SEL_LSB+1:CTRL_SEL_LSB];
      pllBypass <= !ctrl[CTRL_VCO];
    end
  end

  // apb read decode
  always_comb begin
    readData = 32'h0000_0000;
    readError = 1'b0;
    if (paddr == REG_CTRL) begin
      readData = {25'h0, ctrl};
    end else if (paddr == REG_STATUS) begin
      readData = {13'h0, loadState == LD_PARALLEL, spreadSelect, diagSelect, outputDivide,
                  feedbackDivide};
    end else if (paddr == REG_SHIFT) begin
      readData = {14'h0, shiftReg};
    end else if (paddr == REG_SPREAD) begin
      readData = {14'h0, spreadMode, 3'h0, spreadPhase, spreadDepth};
    end else begin
      readError = 1'b1;
    end
  end

  assign apbDone = psel && penable && pready;

  // no wait states, answer prepared in setup
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= readError;
        prdata <= pwrite ? 32'h0000_0000 : readData;
      end else if (apbDone) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // control register write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
    end else if (apbDone && pwrite && paddr == REG_CTRL) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end
endmodule : sdpp_program_port

// [sdpp_program_port_checker.sv]
// concurrent checks on the programming port outputs
`timescale 1ns/1ps
module sdpp_checker import sdpp_pkg::*; (
  // clock and reset
  input logic mclk,
  input logic resetn,
  // parallel pins
  input logic parallelLoadN,
  input logic [8:0] feedbackDivideBits,
  // divider side
  input logic [8:0] feedbackDivide,
  input logic [2:0] outputDivide,
  input logic [2:0] outputDivideRatio,
  input logic pllRelock,
  input logic diagOutput,
  // spread
  input logic [1:0] spreadMode,
  input logic [4:0] spreadPhase,
  // pll control
  input logic pllReset,
  input logic vcoMinimum,
  input logic dividersEnable,
  input logic bankAEnable,
  input logic bankBEnable,
  input logic refCopyEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_par_held;
    (!parallelLoadN) [*6];
  endsequence
  sequence s_par_stable;
    (!parallelLoadN && $stable(feedbackDivideBits)) [*6];
  endsequence
  a_par_pass: assert property (s_par_stable |-> feedbackDivide == feedbackDivideBits)
    else $error("feedback divider not following pins");
  a_par_diag_low: assert property (s_par_held |-> !diagOutput)
    else $error("diag output not low in parallel mode");
  a_par_spread_off: assert property (s_par_held |-> spreadMode == SPREAD_OFF)
    else $error("spread not off in parallel mode");
  a_relock_pulse: assert property ($changed(feedbackDivide) |-> pllRelock ##1 !pllRelock)
    else $error("no single relock pulse on divider change");
  a_relock_cause: assert property (pllRelock |-> $changed(feedbackDivide))
    else $error("relock without divider change");
  a_reset_vco: assert property (pllReset == vcoMinimum && dividersEnable == !pllReset)
    else $error("reset, vco minimum and divider enable disagree");
  a_reset_gates: assert property (pllReset |-> !(bankAEnable || bankBEnable || refCopyEnable))
    else $error("outputs enabled during reset");
  a_ratio_two: assert property (outputDivide == OD_DIV2 |=> outputDivideRatio == 3'h2)
    else $error("divide code 001 not ratio 2");
  a_ratio_five: assert property (outputDivide == OD_DIV5 |=> outputDivideRatio == 3'h5)
    else $error("divide code 100 not ratio 5");
  a_phase_idle: assert property ((spreadMode == SPREAD_OFF) [*2] |-> spreadPhase == 5'h00)
    else $error("triangle running with spread off");
  a_phase_peak: assert property (spreadPhase <= TRI_PEAK)
    else $error("triangle above its peak");
endmodule : sdpp_checker

// [sdpp_triangle.sv]
// triangle phase generator for spread modulation
`timescale 1ns/1ps
module sdpp_triangle import sdpp_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // control
  input wire logic run,
  // phase out
  output logic [4:0] phase
);
  logic [6:0] stepCount;
  logic goingDown;

  always_ff @(posedge mclk) begin
    if (!resetn || !run) begin
      stepCount <= 7'h00;
    end else if (stepCount == STEP_LAST) begin
      stepCount <= 7'h00;
    end else begin
      stepCount <= stepCount + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || !run) begin
      phase <= 5'h00;
      goingDown <= 1'b0;
    end else if (stepCount == STEP_LAST) begin
      if (!goingDown && phase == TRI_PEAK - 5'h01) begin
        goingDown <= 1'b1;
      end else if (goingDown && phase == 5'h01) begin
        goingDown <= 1'b0;
      end
      phase <= goingDown ? phase - 5'h01 : phase + 5'h01;
    end
  end
endmodule : sdpp_triangle

// [test_synth_divider_program_port.sv]
// self-checking bench for the synthesizer programming port
`timescale 1ns/1ps
module test_synth_divider_program_port import sdpp_pkg::*;;
  logic mclk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, fbTap, baTap, diagOutput, pllRelock;
  logic pllReset, bankAEnable, refCopyEnable, pllBypass;
  logic [1:0] refSource;
  logic [7:0] paddr, spreadDepth;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] feedbackDivide, m;
  logic [2:0] outputDivide, od;
  logic [1:0] spreadMode;
  logic [17:0] f;
  wire parallelLoadN, serialClock, serialData, serialLoad;
  wire [8:0] feedbackDivideBits;
  wire [2:0] outputDivideBits;
  logic [22:0] relQ[$];
  logic [33:0] apbQ[$];
  logic [31:0] rngState = 32'h00006E42;
  int badCount = 0;
  int numChecks = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  sdpp_program_port sdpp_program_port_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .parallelLoadN, .feedbackDivideBits,
    .outputDivideBits, .serialClock, .serialData, .serialLoad, .feedbackDividerTap(fbTap),
    .bankATap(baTap), .feedbackDivide, .outputDivide, .outputDivideRatio(), .pllRelock,
    .diagOutput, .spreadMode, .spreadDepth, .spreadPhase(), .pllReset, .vcoMinimum(),
    .dividersEnable(), .bankAEnable, .bankBEnable(), .refCopyEnable, .refSource,
    .pllBypass);
  sdpp_host_model sdpp_host_model_inst (.mclk, .parallelLoadN, .feedbackDivideBits,
    .outputDivideBits, .serialClock, .serialData, .serialLoad);
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : rnd
  function automatic logic [22:0] expect_frame(input logic [17:0] v);
    logic [2:0] lvl;
    logic [1:0] md;
    logic dg;
    lvl = 3'(({1'b0, v[16:14]} + 4'h1) >> 1);
    md = (lvl == 3'h0) ? 2'(SPREAD_OFF) : (v[17] ? 2'(SPREAD_DOWN) : 2'(SPREAD_CENTER));
    dg = (v[13:12] == 2'h0) ? 1'b0 : (v[13:12] == 2'h1) ? v[17] : (v[13] & !v[12]) ? fbTap : baTap;
    return {v[8:0], v[11:9], md, v[17] ? DOWN_DEPTH[lvl] : CENTER_DEPTH[lvl], dg};
  endfunction : expect_frame
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    numChecks++;
    if (seen !== want) begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    if (badCount == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] note);
    apbQ.push_back(note);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge mclk) begin
    logic [33:0] n;
    if (psel && penable && pready) begin
      n = (apbQ.size() != 0) ? apbQ.pop_front() : 'x;
      if (n[33]) check(40'({pslverr, prdata}), 40'(n[32:0]));
      else check(40'(pslverr), 40'(n[32]));
    end
  end
  always @(posedge mclk) begin
    logic [22:0] n;
    if (resetn && pllRelock) begin
      repeat (2) @(posedge mclk);
      n = (relQ.size() != 0) ? relQ.pop_front() : 'x;
      check(40'({feedbackDivide, outputDivide, spreadMode, spreadDepth, diagOutput}), 40'(n));
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      report_and_stop();
    end
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, fbTap, baTap} = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0, {2'b10, 32'(CTRL_RESET)});
    apb(1'b0, 8'h10, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 8'h14, rnd(), {2'b01, 32'h0});
    r = rnd() & 32'h0000007E;
    apb(1'b1, REG_CTRL, r, '0);
    apb(1'b0, REG_CTRL, 32'h0, {2'b10, r});
    relQ.push_back({9'd30, OD_DIV2, 11'h0});
    sdpp_host_model_inst.par(1'b0, 9'd30, OD_DIV2);
    relQ.push_back({9'd27, OD_DIV5, 11'h0});
    sdpp_host_model_inst.par(1'b0, 9'd27, OD_DIV5);
    relQ.push_back({9'd29, OD_DIV4, 11'h0});
    sdpp_host_model_inst.par(1'b1, 9'd29, OD_DIV4);
    apb(1'b1, REG_CTRL, 32'h66, '0);
    apb(1'b1, REG_CTRL, 32'h67, '0);
    repeat (2) @(posedge mclk);
    check(40'({pllReset, bankAEnable, refCopyEnable, refSource, pllBypass}), 40'h24);
    apb(1'b1, REG_CTRL, 32'h66, '0);
    repeat (2) @(posedge mclk);
    check(40'({pllReset, bankAEnable, refCopyEnable, refSource, pllBypass}), 40'h14);
    apb(1'b0, REG_CTRL, 32'h0, {2'b10, 32'h66});
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      m = 9'(i > 7 ? 26 + i % 8 : 26 + i % 6);
      od = (r[1:0] == 2'h0) ? OD_DIV2 : (r[1] ? OD_DIV5 : OD_DIV4);
      fbTap <= r[4];
      baTap <= r[5];
      @(posedge mclk);
      f = {4'(i), r[3:2], od, m};
      relQ.push_back(expect_frame(f));
      sdpp_host_model_inst.shift(f, 18);
      sdpp_host_model_inst.load(1'b1);
      sdpp_host_model_inst.load(1'b0);
      repeat (10) @(posedge mclk);
    end
    apb(1'b0, REG_SHIFT, 32'h0, {2'b10, 32'(f)});
    f = {4'h6, 2'h0, OD_DIV4, 9'd26};
    relQ.push_back(expect_frame(f));
    sdpp_host_model_inst.shift(f, 18);
    sdpp_host_model_inst.load(1'b1);
    relQ.push_back(expect_frame({f[16:0], 1'b1}));
    sdpp_host_model_inst.shift(18'h1, 1);
    sdpp_host_model_inst.load(1'b0);
    sdpp_host_model_inst.shift(18'(rnd()), 18);
    relQ.push_back({9'd31, OD_DIV2, 11'h0});
    sdpp_host_model_inst.par(1'b0, 9'd31, OD_DIV2);
    repeat (20) @(posedge mclk);
    check(40'(relQ.size() + apbQ.size()), 40'h0);
    report_and_stop();
  end
endmodule : test_synth_divider_program_port
bind sdpp_program_port sdpp_checker sdpp_checker_inst (.mclk, .resetn, .parallelLoadN,
  .feedbackDivideBits, .feedbackDivide, .outputDivide, .outputDivideRatio, .pllRelock,
  .diagOutput, .spreadMode, .spreadPhase, .pllReset, .vcoMinimum, .dividersEnable,
  .bankAEnable, .bankBEnable, .refCopyEnable);
